//--- verilog/reset_option_forcing.sv
// module: top of the reset option forcing and CAN select block
//
// Added by the designer: strobed register access.
`timescale 1ns/1ns
module reset_option_forcing
  import reset_option_pkg::*;
(
  // clock and reset
  input wire logic SYS_CLK_I,
  input wire logic NRST_I,
  // option word programming image
  input wire logic [7:0] OPTION_WORD_I,
  // pins
  input wire logic CAN_ENABLE_PIN_I,
  // register port
  input wire logic [15:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  // clock system and module selects
  output logic [1:0] DIV_RATIO_O,
  output logic LONG_DELAY_O,
  output logic DELAY_DONE_O,
  output logic CAN_SELECT_O,
  output logic CAN_REG_HIT_O,
  output logic WAKE_INT_OPT_O,
  output logic RUN_WATCHDOG_O,
  output logic WAIT_WATCHDOG_O,
  output logic PORT_B_PULLDOWN_O,
  output logic PORT_C_PULLDOWN_O
);
  // ==========================================================
  // pin synchroniser and option image
  logic can_meta;
  logic can_sync;
  logic [7:0] option_word;
  logic option_loaded;
  logic [7:0] next_option_word;
  logic next_option_loaded;

  // option word is nonvolatile: no reset clears it, it is only sampled
  always_comb
  begin
    next_option_word = option_word;
    next_option_loaded = 1'b1;
    if (!option_loaded)
      next_option_word = OPTION_WORD_I;
  end

  // image is static while running, so one flop without synchroniser is enough
  always_ff @(posedge SYS_CLK_I)
  begin
    option_word <= next_option_word;
  end

  // two flops: the pin is not timed to the system clock
  always_ff @(posedge SYS_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      can_meta <= 1'b0;
      can_sync <= 1'b0;
      option_loaded <= 1'b0;
    end
    else
    begin
      can_meta <= CAN_ENABLE_PIN_I;
      can_sync <= can_meta;
      option_loaded <= next_option_loaded;
    end
  end

  // ==========================================================
  // control register and power-on delay sequencer
  logic [1:0] ctrl;
  logic [1:0] next_ctrl;
  seq_state_t state;
  seq_state_t next_state;
  logic [12:0] count;
  logic [12:0] next_count;
  option_ratio_if link ();

  // run state is decoded for forcing, status and the done output
  function automatic logic in_run(input seq_state_t s);
    in_run = (s == ST_RUN);
  endfunction : in_run

  assign link.option_word = option_word;
  assign link.can_enable = can_sync;
  assign link.boot_mode = ctrl[CTRL_BOOT_BIT];
  assign link.late_rev = ctrl[CTRL_LATE_BIT];
  // forcing holds until the delay has run out
  assign link.forcing = !in_run(state);

  ratio_select u_sel (.sel(link));

  always_comb
  begin
    next_ctrl = ctrl;
    next_state = state;
    next_count = count;
    if (WR_I && ADDR_I == CTRL_ADDR)
      next_ctrl = WDATA_I[1:0];
    case (state)
      ST_RESET:
      begin
        // option image is valid from here on
        next_count = LONG_DELAY - DELAY_ONE;
        next_state = ST_DELAY;
      end
      ST_DELAY:
      begin
        if (count == DELAY_ZERO)
          next_state = ST_RUN;
        else
          next_count = count - DELAY_ONE;
      end
      ST_RUN:
        next_state = ST_RUN;
      default:
        next_state = ST_RESET;
    endcase
  end

  always_ff @(posedge SYS_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      ctrl <= 2'b00;
      state <= ST_RESET;
      count <= DELAY_ZERO;
    end
    else
    begin
      ctrl <= next_ctrl;
      state <= next_state;
      count <= next_count;
    end
  end

  // ==========================================================
  // address decode and outputs
  function automatic logic can_hit(input logic [15:0] a);
    can_hit = (a >= CAN_REG_LOW) && (a <= CAN_REG_HIGH);
  endfunction : can_hit

  logic [7:0] next_rdata;
  logic next_hit;
  logic [1:0] next_div_ratio;
  logic next_long_delay;
  logic next_done;
  logic next_can_select;
  logic next_wake;
  logic next_run_watchdog;
  logic next_wait_watchdog;
  logic next_pb_pulldown;
  logic next_pc_pulldown;

  always_comb
  begin
    next_rdata = BYTE_ZERO;
    if (!RD_I)
      next_rdata = BYTE_ZERO;
    else if (ADDR_I == OPTION_WORD_ADDR)
      next_rdata = option_word;
    else if (ADDR_I == CTRL_ADDR)
      next_rdata = {6'h00, ctrl};
    else if (ADDR_I == STATUS_ADDR)
      next_rdata = {3'h0, can_sync, link.long_delay, in_run(state), link.ratio};
    // the CAN controller decodes its own reads; only the hit is reported
    next_hit = can_sync && (RD_I || WR_I) && can_hit(ADDR_I);
    // registered copies keep decode glitches away from the clock system
    next_div_ratio = link.ratio;
    next_long_delay = link.long_delay;
    next_done = in_run(state);
    // floating or low pin leaves the controller off
    next_can_select = can_sync;
    next_wake = option_word[WAKE_BIT];
    next_run_watchdog = option_word[RUN_WATCHDOG_OPTION_BIT];
    next_wait_watchdog = option_word[WAIT_WATCHDOG_OPTION_BIT];
    next_pb_pulldown = option_word[PORT_B_PULLDOWN_BIT];
    next_pc_pulldown = option_word[PORT_C_PULLDOWN_BIT];
  end

  always_ff @(posedge SYS_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      RDATA_O <= BYTE_ZERO;
      DIV_RATIO_O <= DIV_TEN;
      LONG_DELAY_O <= 1'b1;
      DELAY_DONE_O <= 1'b0;
      CAN_SELECT_O <= 1'b0;
      CAN_REG_HIT_O <= 1'b0;
      WAKE_INT_OPT_O <= 1'b0;
      RUN_WATCHDOG_O <= 1'b0;
      WAIT_WATCHDOG_O <= 1'b0;
      PORT_B_PULLDOWN_O <= 1'b0;
      PORT_C_PULLDOWN_O <= 1'b0;
    end
    else
    begin
      RDATA_O <= next_rdata;
      DIV_RATIO_O <= next_div_ratio;
      LONG_DELAY_O <= next_long_delay;
      DELAY_DONE_O <= next_done;
      CAN_SELECT_O <= next_can_select;
      CAN_REG_HIT_O <= next_hit;
      WAKE_INT_OPT_O <= next_wake;
      RUN_WATCHDOG_O <= next_run_watchdog;
      WAIT_WATCHDOG_O <= next_wait_watchdog;
      PORT_B_PULLDOWN_O <= next_pb_pulldown;
      PORT_C_PULLDOWN_O <= next_pc_pulldown;
    end
  end
endmodule : reset_option_forcing

//--- verilog/reset_option_pkg.sv
// package: constants for the reset option forcing block
package reset_option_pkg;
  // register map
  localparam logic [15:0] OPTION_WORD_ADDR = 16'h7fde;
  localparam logic [15:0] CAN_REG_LOW = 16'h0020;
  localparam logic [15:0] CAN_REG_HIGH = 16'h003d;
  localparam logic [15:0] CTRL_ADDR = 16'h0101;
  localparam logic [15:0] STATUS_ADDR = 16'h0102;
  // option word field positions
  localparam int WAKE_BIT = 7;
  localparam int DIVIDE_BY_TWO_BIT = 6;
  localparam int DIVB_BIT = 5;
  localparam int RDLY_BIT = 4;
  localparam int RUN_WATCHDOG_OPTION_BIT = 3;
  localparam int WAIT_WATCHDOG_OPTION_BIT = 2;
  localparam int PORT_B_PULLDOWN_BIT = 1;
  localparam int PORT_C_PULLDOWN_BIT = 0;
  // control register bits
  localparam int CTRL_BOOT_BIT = 0;
  localparam int CTRL_LATE_BIT = 1;
  // power-on delay lengths in bus cycles
  localparam logic [12:0] LONG_DELAY = 13'h0fe0;
  localparam logic [12:0] SHORT_DELAY = 13'h0010;
  localparam logic [12:0] DELAY_ONE = 13'h0001;
  localparam logic [12:0] DELAY_ZERO = 13'h0000;
  localparam logic [7:0] OPTION_DEFAULT = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // divide ratio codes
  typedef enum logic [1:0]
  {
    DIV_TWO = 2'b00,
    DIV_FOUR = 2'b01,
    DIV_EIGHT = 2'b10,
    DIV_TEN = 2'b11
  } div_ratio_t;
  typedef enum logic [1:0]
  {
    ST_RESET = 2'b00,
    ST_DELAY = 2'b01,
    ST_RUN = 2'b10
  } seq_state_t;
endpackage : reset_option_pkg

//--- verilog/option_ratio_if.sv
// interface: option word and resolved clock choices
`timescale 1ns/1ns
interface option_ratio_if;
  logic [7:0] option_word;
  logic can_enable;
  logic boot_mode;
  logic late_rev;
  logic forcing;
  logic [1:0] ratio;
  logic long_delay;
  modport top (output option_word, output can_enable, output boot_mode, output late_rev, output forcing,
    input ratio, input long_delay);
  modport sel (input option_word, input can_enable, input boot_mode, input late_rev, input forcing,
    output ratio, output long_delay);
endinterface : option_ratio_if

//--- verilog/ratio_select.sv
// module: picks divide ratio and delay from option word, mode and revision
`timescale 1ns/1ns
module ratio_select
  import reset_option_pkg::*;
(
  option_ratio_if.sel sel
);
  div_ratio_t opt_ratio;

  always_comb
  begin
    if (sel.option_word[DIVIDE_BY_TWO_BIT])
      opt_ratio = DIV_TWO;
    else if (sel.option_word[DIVB_BIT])
      opt_ratio = DIV_EIGHT;
    else
      opt_ratio = DIV_FOUR;
  end

  always_comb
  begin
    sel.ratio = opt_ratio;
    sel.long_delay = ~sel.option_word[RDLY_BIT];
    if (sel.forcing)
    begin
      sel.ratio = DIV_TEN;
      sel.long_delay = 1'b1;
    end
    else if (sel.boot_mode)
    begin
      if (sel.late_rev)
        sel.ratio = DIV_TWO;
      else if (sel.can_enable)
        sel.ratio = DIV_TEN;
      else
        sel.ratio = DIV_TWO;
    end
  end
endmodule : ratio_select

//--- tb/reset_option_assertions.sv
// checker: port-level assertions for the reset option forcing block
`timescale 1ns/1ns
module reset_option_assertions
  import reset_option_pkg::*;
(
  // clock, reset and inputs
  input wire logic SYS_CLK_I,
  input wire logic NRST_I,
  input wire logic [7:0] OPTION_WORD_I,
  input wire logic CAN_ENABLE_PIN_I,
  input wire logic [15:0] ADDR_I,
  input wire logic WR_I,
  input wire logic RD_I,
  // outputs watched
  input wire logic [7:0] RDATA_O,
  input wire logic [1:0] DIV_RATIO_O,
  input wire logic LONG_DELAY_O,
  input wire logic DELAY_DONE_O,
  input wire logic CAN_SELECT_O,
  input wire logic CAN_REG_HIT_O,
  input wire logic WAKE_INT_OPT_O
);
  default clocking @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!NRST_I);
  logic acc_can;
  assign acc_can = (RD_I || WR_I) && ADDR_I >= CAN_REG_LOW && ADDR_I <= CAN_REG_HIGH;
  // =====
  // assertions
  property p_forced_ratio;
    !DELAY_DONE_O |-> DIV_RATIO_O == DIV_TEN;
  endproperty
  a_forced_ratio: assert property (p_forced_ratio) else $error("ratio not forced in delay");
  property p_forced_delay;
    !DELAY_DONE_O |-> LONG_DELAY_O;
  endproperty
  a_forced_delay: assert property (p_forced_delay) else $error("long delay not forced");
  // select may drop in the same cycle, so a falling select excuses the pulse
  property p_hit_cause;
    acc_can && CAN_SELECT_O |=> CAN_REG_HIT_O || !CAN_SELECT_O;
  endproperty
  a_hit_cause: assert property (p_hit_cause) else $error("missing hit pulse");
  property p_hit_only;
    CAN_REG_HIT_O |-> $past(acc_can);
  endproperty
  a_hit_only: assert property (p_hit_only) else $error("hit without access");
  property p_can_high;
    CAN_ENABLE_PIN_I [*3] |=> CAN_SELECT_O;
  endproperty
  a_can_high: assert property (p_can_high) else $error("select did not follow pin");
  property p_can_low;
    !CAN_ENABLE_PIN_I [*3] |=> !CAN_SELECT_O;
  endproperty
  a_can_low: assert property (p_can_low) else $error("select stuck with pin low");
  property p_option_read;
    RD_I && ADDR_I == OPTION_WORD_ADDR |=> RDATA_O == $past(OPTION_WORD_I);
  endproperty
  a_option_read: assert property (p_option_read) else $error("option word read wrong");
  property p_wake_bit;
    DELAY_DONE_O |-> WAKE_INT_OPT_O == OPTION_WORD_I[WAKE_BIT];
  endproperty
  a_wake_bit: assert property (p_wake_bit) else $error("wake option bit wrong");
  c_hit: cover property (CAN_REG_HIT_O);
  c_done: cover property ($rose(DELAY_DONE_O));
  c_boot_ten: cover property (DELAY_DONE_O && DIV_RATIO_O == DIV_TEN);
endmodule : reset_option_assertions
bind reset_option_forcing reset_option_assertions u_chk
(
  .SYS_CLK_I(SYS_CLK_I), .NRST_I(NRST_I), .OPTION_WORD_I(OPTION_WORD_I), .CAN_ENABLE_PIN_I(CAN_ENABLE_PIN_I),
  .ADDR_I(ADDR_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .DIV_RATIO_O(DIV_RATIO_O),
  .LONG_DELAY_O(LONG_DELAY_O), .DELAY_DONE_O(DELAY_DONE_O), .CAN_SELECT_O(CAN_SELECT_O),
  .CAN_REG_HIT_O(CAN_REG_HIT_O), .WAKE_INT_OPT_O(WAKE_INT_OPT_O)
);

//--- tb/testbench.sv
// testbench: directed checks of the reset option forcing block
`timescale 1ns/1ns
module testbench
  import reset_option_pkg::*;
;
  logic clk, hit, hit_seen, long_dly, done, can_sel, wake, run_watchdog_option, wait_watchdog_option, port_b_pulldown, port_c_pulldown;
  logic nrst = 1'b0, pin = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
  logic [7:0] opt = 8'h00, wdata = 8'h00, rdata, rd_seen;
  logic [15:0] addr = 16'h0000;
  logic [1:0] ratio;
  int n_fail = 0, tests_run = 0, cyc = 0;
  reset_option_forcing dut
  (
    .SYS_CLK_I(clk), .NRST_I(nrst), .OPTION_WORD_I(opt), .CAN_ENABLE_PIN_I(pin), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr_en), .RD_I(rd_en), .RDATA_O(rdata), .DIV_RATIO_O(ratio),
    .LONG_DELAY_O(long_dly), .DELAY_DONE_O(done), .CAN_SELECT_O(can_sel), .CAN_REG_HIT_O(hit),
    .WAKE_INT_OPT_O(wake), .RUN_WATCHDOG_O(run_watchdog_option), .WAIT_WATCHDOG_O(wait_watchdog_option),
    .PORT_B_PULLDOWN_O(port_b_pulldown), .PORT_C_PULLDOWN_O(port_c_pulldown)
  );
  // =====
  // tasks
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= w;
    rd_en <= !w;
    @(posedge clk);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    #1;
    rd_seen = rdata;
    hit_seen = hit;
  endtask : bus
  // also serves as a mid-run reset when called after an earlier run
  task automatic run_opt(input logic [7:0] o, input logic [1:0] er, input logic el);
    @(posedge clk);
    nrst <= 1'b0;
    opt <= o;
    repeat (2) @(posedge clk);
    #1;
    chk({long_dly, done, 4'h0, ratio}, {2'b10, 4'h0, DIV_TEN});
    @(posedge clk);
    nrst <= 1'b1;
    repeat (4000) @(posedge clk);
    #1;
    chk({long_dly, done, 4'h0, ratio}, {2'b10, 4'h0, DIV_TEN});
    // one load edge, the counted delay, then one output edge
    repeat (LONG_DELAY - 4000 + 1) @(posedge clk);
    #1;
    chk({long_dly, done, 4'h0, ratio}, {2'b10, 4'h0, DIV_TEN});
    @(posedge clk);
    #1;
    chk({long_dly, done, 4'h0, ratio}, {el, 5'h10, er});
    chk({3'h0, wake, run_watchdog_option, wait_watchdog_option, port_b_pulldown, port_c_pulldown}, {3'h0, o[7], o[3:0]});
    bus(1'b0, OPTION_WORD_ADDR, 8'h00);
    chk(rd_seen, o);
    bus(1'b1, OPTION_WORD_ADDR, ~o);
    bus(1'b0, OPTION_WORD_ADDR, 8'h00);
    chk(rd_seen, o);
  endtask : run_opt
  task automatic boot_case(input logic [7:0] c, input logic p, input logic [1:0] e);
    @(posedge clk);
    pin <= p;
    bus(1'b1, CTRL_ADDR, c);
    repeat (6) @(posedge clk);
    #1;
    chk(8'(ratio), 8'(e));
    bus(1'b0, CTRL_ADDR, 8'h00);
    chk(rd_seen, c);
    bus(1'b0, STATUS_ADDR, 8'h00);
    chk(rd_seen, {3'h0, p, 1'b0, 1'b1, e});
  endtask : boot_case
  task automatic can_case(input logic p, input logic [15:0] a, input logic e);
    @(posedge clk);
    pin <= p;
    repeat (4) @(posedge clk);
    bus(1'b0, a, 8'h00);
    chk({6'h00, can_sel, hit_seen}, {6'h00, p, e});
    chk(rd_seen, BYTE_ZERO);
  endtask : can_case
  // =====
  // clock, watchdog and main sequence
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      stop_test();
    end
  end
  initial
  begin
    run_opt(8'h4b, DIV_TWO, 1'b1);
    run_opt(8'h00, DIV_FOUR, 1'b1);
    run_opt(8'hb0, DIV_EIGHT, 1'b0);
    boot_case(8'h01, 1'b1, DIV_TEN);
    boot_case(8'h01, 1'b0, DIV_TWO);
    boot_case(8'h03, 1'b1, DIV_TWO);
    boot_case(8'h03, 1'b0, DIV_TWO);
    boot_case(8'h00, 1'b1, DIV_EIGHT);
    can_case(1'b1, CAN_REG_LOW, 1'b1);
    can_case(1'b1, CAN_REG_HIGH, 1'b1);
    can_case(1'b1, 16'h001f, 1'b0);
    can_case(1'b1, 16'h003e, 1'b0);
    can_case(1'b0, CAN_REG_LOW, 1'b0);
    stop_test();
  end
endmodule : testbench
